// [acsp_cfg_regs.sv]
// Purpose: configuration register bank with registered read port
// Assumes: clear is a one-cycle pulse from the soft reset key write or the pin-mode power-down fall
// Notes:   reserved and unmapped addresses read as zero
`timescale 1ns/1ps
`include "acsp_consts.svh"

module acsp_cfg_regs
  import acsp_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [6:0] rd_addr,
  // results
  output logic      [7:0] rd_data,
  output logic      [7:0] out_fmt_reg,
  output logic      [7:0] div_fmt_reg
);

  logic [7:0] regs_reg [`ACSP_NUM_REGS];

  function automatic logic [7:0] def_of(input int idx);
    case (idx)
      0:       def_of = `ACSP_DEF_POWER;
      3:       def_of = `ACSP_DEF_TIMING;
      default: def_of = `ACSP_DEF_ZERO;
    endcase
  endfunction

  wire wr_ok = (wr_addr < 7'(`ACSP_NUM_REGS))
               && (wr_addr != `ACSP_ADDR_RESERVED);

  // ========================================================
  // storage
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `ACSP_NUM_REGS; i++)
        regs_reg[i] <= def_of(i);
    end
    else if (clear)
    begin
      for (int i = 0; i < `ACSP_NUM_REGS; i++)
        regs_reg[i] <= def_of(i);
    end
    else if (wr_en && wr_ok)
      regs_reg[wr_addr[3:0]] <= wr_data;
  end

  // ========================================================
  // read port
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rd_data <= 8'h00;
    else if (rd_addr < 7'(`ACSP_NUM_REGS)
             && rd_addr != `ACSP_ADDR_RESERVED)
      rd_data <= regs_reg[rd_addr[3:0]];
    else
      rd_data <= 8'h00;
  end

  assign out_fmt_reg = regs_reg[1];
  assign div_fmt_reg = regs_reg[6];

endmodule

// [acsp_config_port.sv]
// Purpose: serial/parallel configuration front end and result pipeline
// Assumes: serial clock half period spans at least four clock cycles
// Notes:   all pins pass a two-stage synchroniser first
`timescale 1ns/1ps
`include "acsp_consts.svh"

module acsp_config_port
  import acsp_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // configuration pins
  input  wire logic       serial_port_enable_n,
  input  wire logic       serial_data_or_format_pin,
  input  wire logic       serial_clock_or_divider_pin,
  input  wire logic       select_or_output_mode_pin,
  input  wire logic       format_pin_open,
  input  wire logic       divider_pin_open,
  input  wire logic       output_mode_pin_open,
  input  wire logic       power_down_input,
  output logic            serial_data_out,
  output logic            serial_data_oe,
  // internal status
  input  wire logic       rom_read_busy,
  input  wire logic       rom_read_valid,
  input  wire logic       dll_locked,
  // conversion data
  input  wire logic [9:0] sample_a_in,
  input  wire logic [9:0] sample_b_in,
  input  wire logic       sample_valid_in,
  output logic      [9:0] result_a_out,
  output logic      [9:0] result_b_out,
  output logic            result_valid_out,
  // effective configuration
  output acsp_fmt_t       output_format,
  output acsp_div_t       clock_divide,
  output acsp_bus_t       bus_mode
);

  // ========================================================
  // synchronisers
  logic [`ACSP_SYNC_W-1:0] pin_meta;
  logic [`ACSP_SYNC_W-1:0] pin_sync;
  logic [`ACSP_SYNC_W-1:0] pin_prev;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= `ACSP_SYNC_RST;
      pin_sync <= `ACSP_SYNC_RST;
      pin_prev <= `ACSP_SYNC_RST;
    end
    else
    begin
      pin_meta <= {power_down_input, output_mode_pin_open,
                   divider_pin_open, format_pin_open,
                   select_or_output_mode_pin,
                   serial_clock_or_divider_pin,
                   serial_data_or_format_pin, serial_port_enable_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  wire s_serial_port_enable_n_n = pin_sync[0];
  wire s_sdi    = pin_sync[1];
  wire s_sclk   = pin_sync[2];
  wire s_cs     = pin_sync[3];
  wire s_fopen  = pin_sync[4];
  wire s_dopen  = pin_sync[5];
  wire s_mopen  = pin_sync[6];
  wire s_pd     = pin_sync[7];

  wire spi_mode  = !s_serial_port_enable_n_n;
  wire active    = spi_mode && !s_cs;
  wire sclk_rise = active && s_sclk && !pin_prev[2];
  wire sclk_fall = active && !s_sclk && pin_prev[2];

  // ========================================================
  // serial frame
  acsp_state_t state_reg;
  logic [4:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [6:0]  addr_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  mem_rd;

  wire [7:0] rx_byte = {shift_reg[6:0], s_sdi};

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg   <= ST_CMD;
      bit_cnt_reg <= 5'd0;
      shift_reg   <= 8'h00;
      addr_reg    <= 7'h00;
    end
    else if (!active)
    begin
      state_reg   <= ST_CMD;
      bit_cnt_reg <= 5'd0;
    end
    else if (sclk_rise && state_reg != ST_DONE)
    begin
      shift_reg   <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 5'd1;
      case (state_reg)
        ST_CMD:
        begin
          if (bit_cnt_reg == `ACSP_CTRL_BITS - 5'd1)
          begin
            addr_reg  <= rx_byte[6:0];
            state_reg <= rx_byte[7] ? ST_RDATA : ST_WDATA;
          end
        end
        ST_WDATA, ST_RDATA:
        begin
          if (bit_cnt_reg == `ACSP_FRAME_BITS - 5'd1)
            state_reg <= ST_DONE;
        end
        default: state_reg <= ST_DONE;
      endcase
    end
  end

  // ========================================================
  // write commit and register resets
  wire wr_commit = sclk_rise && state_reg == ST_WDATA
                   && bit_cnt_reg == `ACSP_FRAME_BITS - 5'd1;
  wire soft_clear = wr_commit && addr_reg == `ACSP_ADDR_RST_STAT
                    && rx_byte == `ACSP_SOFT_RESET_KEY;
  wire pd_clear = !spi_mode && pin_prev[7] && !s_pd;
  wire reg_clear = soft_clear || pd_clear;

  logic [7:0] out_fmt_q;
  logic [7:0] div_fmt_q;

  acsp_cfg_regs u_regs (
    .clock       (clock),
    .rst         (rst),
    .clear       (reg_clear),
    .wr_en       (wr_commit),
    .wr_addr     (addr_reg),
    .wr_data     (rx_byte),
    .rd_addr     (addr_reg),
    .rd_data     (mem_rd),
    .out_fmt_reg (out_fmt_q),
    .div_fmt_reg (div_fmt_q)
  );

  // ========================================================
  // read return
  wire [7:0] status_byte = {2'b00, rom_read_busy, rom_read_valid,
                            1'b0, 1'b1, 1'b0, dll_locked};
  wire [7:0] rd_byte = (addr_reg == `ACSP_ADDR_RST_STAT)
                       ? status_byte : mem_rd;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      serial_data_out <= 1'b0;
      serial_data_oe  <= 1'b0;
      tx_reg          <= 8'h00;
    end
    else if (!active)
      serial_data_oe <= 1'b0;
    else if (sclk_fall && state_reg == ST_RDATA)
    begin
      serial_data_oe <= 1'b1;
      if (bit_cnt_reg == `ACSP_CTRL_BITS)
      begin
        serial_data_out <= rd_byte[7];
        tx_reg          <= {rd_byte[6:0], 1'b0};
      end
      else
      begin
        serial_data_out <= tx_reg[7];
        tx_reg          <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ========================================================
  // effective configuration
  function automatic acsp_fmt_t fmt_of(input logic [1:0] v);
    case (v)
      2'b01:   fmt_of = FMT_OFFSET;
      2'b10:   fmt_of = FMT_GRAY;
      default: fmt_of = FMT_TWOS;
    endcase
  endfunction

  function automatic acsp_div_t div_of(input logic [1:0] v);
    case (v)
      2'b01:   div_of = DIV_2;
      2'b10:   div_of = DIV_4;
      default: div_of = DIV_1;
    endcase
  endfunction

  // open pins win over level; three-level sensing is in the pad
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      output_format <= FMT_TWOS;
      clock_divide  <= DIV_1;
      bus_mode      <= BUS_DUAL;
    end
    else if (!spi_mode)
    begin
      output_format <= s_fopen ? FMT_GRAY
                     : (s_sdi ? FMT_OFFSET : FMT_TWOS);
      clock_divide  <= s_dopen ? DIV_4
                     : (s_sclk ? DIV_2 : DIV_1);
      bus_mode      <= s_mopen ? BUS_MUX_B
                     : (s_cs ? BUS_MUX_A : BUS_DUAL);
    end
    else
    begin
      output_format <= fmt_of(div_fmt_q[`ACSP_FMT_LSB+:2]);
      clock_divide  <= div_of(div_fmt_q[`ACSP_DIV_LSB+:2]);
      bus_mode      <= !out_fmt_q[`ACSP_MUX_BIT] ? BUS_DUAL
                     : (out_fmt_q[`ACSP_MUX_CH_BIT] ? BUS_MUX_B
                                                    : BUS_MUX_A);
    end
  end

  // ========================================================
  // result pipeline, coding applied on entry
  function automatic logic [9:0] enc(input logic [9:0] v,
                                     input acsp_fmt_t f);
    case (f)
      FMT_OFFSET: enc = v;
      FMT_GRAY:   enc = v ^ {1'b0, v[9:1]};
      default:    enc = {~v[9], v[8:0]};
    endcase
  endfunction

  logic [9:0] pipe_a [`ACSP_LATENCY];
  logic [9:0] pipe_b [`ACSP_LATENCY];
  logic [`ACSP_LATENCY-1:0] pipe_v;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pipe_v <= '0;
      for (int i = 0; i < `ACSP_LATENCY; i++)
      begin
        pipe_a[i] <= 10'h000;
        pipe_b[i] <= 10'h000;
      end
    end
    else
    begin
      pipe_v    <= {pipe_v[`ACSP_LATENCY-2:0], sample_valid_in};
      pipe_a[0] <= enc(sample_a_in, output_format);
      pipe_b[0] <= enc(sample_b_in, output_format);
      for (int i = 1; i < `ACSP_LATENCY; i++)
      begin
        pipe_a[i] <= pipe_a[i-1];
        pipe_b[i] <= pipe_b[i-1];
      end
    end
  end

  assign result_a_out     = pipe_a[`ACSP_LATENCY-1];
  assign result_b_out     = pipe_b[`ACSP_LATENCY-1];
  assign result_valid_out = pipe_v[`ACSP_LATENCY-1];

  // ========================================================
  // checks
  property p_latency;
    @(posedge clock) disable iff (rst)
    result_valid_out == $past(sample_valid_in, 9);
  endproperty
  a_latency: assert property (p_latency)
    else $error("result latency is not nine cycles");

  property p_fmt_gray;
    @(posedge clock) disable iff (rst)
    (!spi_mode && s_fopen) |=> output_format == FMT_GRAY;
  endproperty
  a_fmt_gray: assert property (p_fmt_gray)
    else $error("open format pin did not give gray");

  property p_div_two;
    @(posedge clock) disable iff (rst)
    (!spi_mode && !s_dopen && s_sclk) |=> clock_divide == DIV_2;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("high divider pin did not give divide by two");

  property p_bus_dual;
    @(posedge clock) disable iff (rst)
    (!spi_mode && !s_mopen && !s_cs) |=> bus_mode == BUS_DUAL;
  endproperty
  a_bus_dual: assert property (p_bus_dual)
    else $error("low mode pin did not give dual bus");

  property p_idle;
    @(posedge clock) disable iff (rst)
    !active |=> !serial_data_oe && bit_cnt_reg == 5'd0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("serial port active while deselected");

  property p_count;
    @(posedge clock) disable iff (rst)
    (sclk_rise && state_reg == ST_CMD)
      |=> bit_cnt_reg == $past(bit_cnt_reg) + 5'd1;
  endproperty
  a_count: assert property (p_count)
    else $error("rising edge not counted");

  property p_msb;
    @(posedge clock) disable iff (rst)
    (sclk_fall && state_reg == ST_RDATA
     && bit_cnt_reg == `ACSP_CTRL_BITS)
      |=> serial_data_oe && serial_data_out == $past(rd_byte[7]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("read msb not driven after eighth rise");

  property p_status;
    @(posedge clock) disable iff (rst)
    (sclk_fall && state_reg == ST_RDATA
     && bit_cnt_reg == `ACSP_CTRL_BITS
     && addr_reg == `ACSP_ADDR_RST_STAT) |=> !serial_data_out;
  endproperty
  a_status: assert property (p_status)
    else $error("status msb not zero");

  property p_soft;
    @(posedge clock) disable iff (rst)
    (wr_commit && addr_reg == `ACSP_ADDR_RST_STAT
     && rx_byte == `ACSP_SOFT_RESET_KEY)
      |=> out_fmt_q == `ACSP_DEF_ZERO && div_fmt_q == `ACSP_DEF_ZERO;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset key did not restore defaults");

  property p_key_only;
    @(posedge clock) disable iff (rst)
    (wr_commit && addr_reg == `ACSP_ADDR_RST_STAT
     && rx_byte != `ACSP_SOFT_RESET_KEY && !pd_clear)
      |=> $stable(out_fmt_q) && $stable(div_fmt_q);
  endproperty
  a_key_only: assert property (p_key_only)
    else $error("wrong key changed the registers");

  property p_pd;
    @(posedge clock) disable iff (rst)
    (s_serial_port_enable_n_n && $fell(s_pd)) |-> reg_clear;
  endproperty
  a_pd: assert property (p_pd)
    else $error("power-down fall did not reset registers");

endmodule

// [acsp_consts.svh]
// Purpose: constants of the converter configuration port
// Assumes: byte-wide registers, 7-bit register addresses
// Notes:   included by the design modules and by the bench
`ifndef ACSP_CONSTS_SVH
`define ACSP_CONSTS_SVH

// ==========================================================
// register map
`define ACSP_ADDR_POWER      7'h00
`define ACSP_ADDR_OUT_FMT    7'h01
`define ACSP_ADDR_DOUT_PM    7'h02
`define ACSP_ADDR_TIMING     7'h03
`define ACSP_ADDR_TERM_A     7'h04
`define ACSP_ADDR_TERM_B     7'h05
`define ACSP_ADDR_DIV_FMT    7'h06
`define ACSP_ADDR_RESERVED   7'h07
`define ACSP_ADDR_CMODE      7'h08
`define ACSP_ADDR_RST_STAT   7'h0a
`define ACSP_NUM_REGS        9

// ==========================================================
// reset values
`define ACSP_DEF_POWER       8'h03
`define ACSP_DEF_TIMING      8'h80
`define ACSP_DEF_ZERO        8'h00
`define ACSP_SOFT_RESET_KEY  8'h5a

// ==========================================================
// field positions
`define ACSP_MUX_BIT         1
`define ACSP_MUX_CH_BIT      2
`define ACSP_DIV_LSB         0
`define ACSP_FMT_LSB         2
`define ACSP_ST_BUSY_BIT     5
`define ACSP_ST_VALID_BIT    4
`define ACSP_ST_ONE_BIT      2
`define ACSP_ST_LOCK_BIT     0

// ==========================================================
// serial frame and pipeline timing
`define ACSP_CTRL_BITS       5'd8
`define ACSP_FRAME_BITS      5'd16
`define ACSP_LATENCY         9
`define ACSP_SYNC_W          8
// idle pin mode: strap, select and serial clock high
`define ACSP_SYNC_RST        8'h0d

`endif

// [acsp_host_model.sv]
// Purpose: host side of the three-wire configuration port
// Assumes: half period of the serial clock is HALF clock cycles
// Notes:   released data line toggles every clock, never holds a value
`timescale 1ns/1ps

module acsp_host_model
#(
  parameter int HALF = 8
)
(
  // clock
  input  wire logic clock,
  // device side of the data pin
  input  wire logic dev_out,
  input  wire logic dev_oe,
  // host pins
  output logic      ser_clk,
  output logic      sel_n,
  output logic      ser_data
);
  logic drv_en;
  logic drv_val;
  logic float_q = 1'b0;

  // ========================================================
  // wire resolution
  initial
  begin
    ser_clk = 1'b0;
    sel_n   = 1'b1;
    drv_en  = 1'b0;
    drv_val = 1'b0;
  end

  // nobody driving: a moving pattern, so a stale bit cannot pass
  always_ff @(posedge clock)
    float_q <= ~float_q;

  assign ser_data = dev_oe ? dev_out : (drv_en ? drv_val : float_q);

  // ========================================================
  // one frame; sel low only when asked, to test ignored traffic
  task automatic xfer(input logic rw, input logic [6:0] addr,
                      input logic [7:0] wd, input logic sel,
                      output logic [7:0] rd);
    logic [15:0] frame;
    frame = {rw, addr, wd};
    rd = 8'h00;
    @(negedge clock);
    sel_n   = ~sel;
    drv_en  = 1'b1;
    drv_val = frame[15];
    repeat (HALF) @(negedge clock);
    for (int i = 15; i >= 0; i--)
    begin
      if (i < 8)
        rd[i] = ser_data;
      ser_clk = 1'b1;
      repeat (HALF) @(negedge clock);
      ser_clk = 1'b0;
      if (rw && i == 8)
        drv_en = 1'b0;
      else if (i > 0)
        drv_val = frame[i-1];
      repeat (HALF) @(negedge clock);
    end
    sel_n  = 1'b1;
    drv_en = 1'b0;
    repeat (2 * HALF) @(negedge clock);
  endtask
endmodule

// [acsp_pkg.sv]
// Purpose: types of the converter configuration port
// Assumes: acsp_consts.svh holds every number
// Notes:   enums carry explicit binary codes
package acsp_pkg;

  // ========================================================
  // serial port states
  typedef enum logic [1:0] {
    ST_CMD   = 2'b00,
    ST_WDATA = 2'b01,
    ST_RDATA = 2'b10,
    ST_DONE  = 2'b11
  } acsp_state_t;

  // ========================================================
  // configuration modes
  typedef enum logic [1:0] {
    FMT_TWOS   = 2'b00,
    FMT_OFFSET = 2'b01,
    FMT_GRAY   = 2'b10
  } acsp_fmt_t;

  typedef enum logic [1:0] {
    DIV_1 = 2'b00,
    DIV_2 = 2'b01,
    DIV_4 = 2'b10
  } acsp_div_t;

  typedef enum logic [1:0] {
    BUS_DUAL  = 2'b00,
    BUS_MUX_A = 2'b01,
    BUS_MUX_B = 2'b10
  } acsp_bus_t;

endpackage

// [tb_top.sv]
// Purpose: self-checking bench of the configuration port
// Assumes: host model frames, 250 MHz clock
// Notes:   pin levels muxed onto shared pins while the strap is high
`timescale 1ns/1ps
`include "acsp_consts.svh"

module tb_top
  import acsp_pkg::*;
;
  localparam int LAT = `ACSP_LATENCY;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       strap_n = 1'b0;
  logic       fmt_lvl = 1'b0;
  logic       div_lvl = 1'b0;
  logic       mode_lvl = 1'b0;
  logic       fmt_open = 1'b0;
  logic       div_open = 1'b0;
  logic       mode_open = 1'b0;
  logic       pdown = 1'b0;
  logic       rom_busy = 1'b0;
  logic       rom_valid = 1'b0;
  logic       dll_lock = 1'b0;
  logic [9:0] samp_a = 10'h000;
  logic [9:0] samp_b = 10'h000;
  logic       samp_v = 1'b0;
  logic       ser_clk;
  logic       sel_n;
  logic       ser_data;
  logic       dout;
  logic       doe;
  logic [9:0] res_a;
  logic [9:0] res_b;
  logic       res_v;
  acsp_fmt_t  ofmt;
  acsp_div_t  cdiv;
  acsp_bus_t  bmode;
  int         fails = 0;
  int         num_checks = 0;
  logic [7:0] junk;

  always #2 clock = ~clock;

  acsp_config_port i_dut (
    .clock                       (clock),
    .rst                         (rst),
    .serial_port_enable_n        (strap_n),
    .serial_data_or_format_pin   (strap_n ? fmt_lvl : ser_data),
    .serial_clock_or_divider_pin (strap_n ? div_lvl : ser_clk),
    .select_or_output_mode_pin   (strap_n ? mode_lvl : sel_n),
    .format_pin_open             (fmt_open),
    .divider_pin_open            (div_open),
    .output_mode_pin_open        (mode_open),
    .power_down_input            (pdown),
    .serial_data_out             (dout),
    .serial_data_oe              (doe),
    .rom_read_busy               (rom_busy),
    .rom_read_valid              (rom_valid),
    .dll_locked                  (dll_lock),
    .sample_a_in                 (samp_a),
    .sample_b_in                 (samp_b),
    .sample_valid_in             (samp_v),
    .result_a_out                (res_a),
    .result_b_out                (res_b),
    .result_valid_out            (res_v),
    .output_format               (ofmt),
    .clock_divide                (cdiv),
    .bus_mode                    (bmode)
  );

  acsp_host_model #(.HALF(8)) i_host (
    .clock    (clock),
    .dev_out  (dout),
    .dev_oe   (doe),
    .ser_clk  (ser_clk),
    .sel_n    (sel_n),
    .ser_data (ser_data)
  );

  // ========================================================
  // helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    i_host.xfer(1'b0, a, d, 1'b1, v);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.xfer(1'b1, a, 8'h00, 1'b1, v);
    chk(v, e);
  endtask

  function automatic logic [7:0] pat(input int a);
    return {a[3:0], ~a[3:0]};
  endfunction

  function automatic logic [7:0] def_val(input int a);
    return (a == 0) ? `ACSP_DEF_POWER :
           (a == 3) ? `ACSP_DEF_TIMING : `ACSP_DEF_ZERO;
  endfunction

  function automatic logic [9:0] enc(input logic [9:0] v,
                                     input acsp_fmt_t f);
    case (f)
      FMT_TWOS: return {~v[9], v[8:0]};
      FMT_GRAY: return v ^ (v >> 1);
      default:  return v;
    endcase
  endfunction

  // samples stream through; each but the last LAT checked LAT edges after capture
  task automatic stream(input acsp_fmt_t f);
    logic [9:0] ha [0:31];
    logic [9:0] hb [0:31];
    logic       hv [0:31];
    for (int j = 0; j < 32; j++)
    begin
      @(negedge clock);
      if (j >= LAT)
      begin
        chk(res_a, enc(ha[j-LAT], f));
        chk(res_b, enc(hb[j-LAT], f));
        chk(res_v, hv[j-LAT]);
      end
      ha[j] = 10'(j * 37 + 5);
      hb[j] = ~ha[j];
      hv[j] = (j % 3 != 0);
      samp_a = ha[j];
      samp_b = hb[j];
      samp_v = hv[j];
    end
  endtask

  // ========================================================
  // main sequence
  initial
  begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (8) @(negedge clock);
    for (int a = 0; a <= 8; a++)
      rd_chk(7'(a), def_val(a));
    for (int a = 0; a <= 8; a++)
      wr(7'(a), pat(a));
    wr(7'h09, 8'ha5);
    wr(7'h7f, 8'ha5);
    for (int a = 0; a <= 9; a++)
      rd_chk(7'(a), (a == 7 || a == 9) ? 8'h00 : pat(a));
    rd_chk(7'h7f, 8'h00);
    chk(bmode, BUS_MUX_B);
    chk(cdiv, DIV_2);
    chk(ofmt, FMT_GRAY);
    for (int i = 0; i < 3; i++)
    begin
      wr(7'h01, (i == 0) ? 8'h00 : (i == 1) ? 8'h02 : 8'h06);
      chk(bmode, acsp_bus_t'(i));
    end
    wr(7'h01, pat(1));
    i_host.xfer(1'b0, 7'h00, 8'h77, 1'b0, junk);
    rd_chk(7'h00, pat(0));
    wr(`ACSP_ADDR_RST_STAT, 8'h55);
    rd_chk(7'h00, pat(0));
    for (int k = 0; k < 4; k++)
    begin
      rom_busy  = k[0];
      rom_valid = k[1];
      dll_lock  = ~k[0];
      rd_chk(`ACSP_ADDR_RST_STAT,
             {2'b00, k[0], k[1], 2'b01, 1'b0, ~k[0]});
    end
    wr(`ACSP_ADDR_RST_STAT, `ACSP_SOFT_RESET_KEY);
    for (int a = 0; a <= 8; a++)
      rd_chk(7'(a), def_val(a));
    chk(bmode, BUS_DUAL);
    chk(cdiv, DIV_1);
    chk(ofmt, FMT_TWOS);
    // pin-mode power-down edge clears what serial writes left
    wr(7'h00, 8'h5c);
    strap_n = 1'b1;
    repeat (8) @(negedge clock);
    pdown = 1'b1;
    repeat (8) @(negedge clock);
    pdown = 1'b0;
    repeat (8) @(negedge clock);
    strap_n = 1'b0;
    repeat (8) @(negedge clock);
    rd_chk(7'h00, `ACSP_DEF_POWER);
    strap_n = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      fmt_lvl   = (i == 1);
      fmt_open  = (i == 2);
      div_lvl   = (i == 1);
      div_open  = (i == 2);
      mode_lvl  = (i == 1);
      mode_open = (i == 2);
      repeat (8) @(negedge clock);
      chk(ofmt, acsp_fmt_t'(i));
      chk(cdiv, acsp_div_t'(i));
      chk(bmode, acsp_bus_t'(i));
      stream(acsp_fmt_t'(i));
    end
    wrap_up();
  end

  // ========================================================
  // watchdog, far beyond the roughly 16000 cycles of the run
  initial
  begin
    repeat (60000) @(posedge clock);
    fails++;
    wrap_up();
  end
endmodule
